/* File: common/tmc_pkg.sv */
// constants and types for the timer mode control block
package tmc_pkg;
    localparam int          NCH          = 2;
    localparam int          CW           = 16;
    localparam logic [15:0] MAX_COUNT    = 16'hffff;

    // printed offsets are not word aligned: kept as indices
    localparam logic [31:0] MODE_IDX0    = 32'hfffff606;
    localparam logic [31:0] MODE_IDX1    = 32'hfffff616;
    localparam logic [31:0] ADDR_MODE0   = {MODE_IDX0[29:0], 2'b00};
    localparam logic [31:0] ADDR_MODE1   = {MODE_IDX1[29:0], 2'b00};

    // per channel block: base = channel * stride
    localparam logic [31:0] CH_STRIDE    = 32'h0000_0020;
    localparam logic [31:0] OFS_MATCH_A  = 32'h0000_0000;
    localparam logic [31:0] OFS_MATCH_B  = 32'h0000_0004;
    localparam logic [31:0] OFS_PRESCALE = 32'h0000_0008;
    localparam logic [31:0] OFS_COUNT    = 32'h0000_000c;
    localparam logic [31:0] OFS_BITOP    = 32'h0000_0010;
    localparam logic [31:0] ADDR_IRQ_ST  = 32'h0000_0040;
    localparam logic [31:0] ADDR_IRQ_MSK = 32'h0000_0044;

    // mode control layout
    localparam int          F_RUN_HI     = 3;
    localparam int          F_RUN_LO     = 2;
    localparam int          F_TSEL       = 1;
    localparam int          F_WRAP       = 0;
    localparam logic [7:0]  MODE_RST     = 8'h00;
    localparam logic [2:0]  BIT_IDX_MAX  = 3'h3;
    localparam int          F_BITVAL     = 3;

    // prescale layout: count divider select and edge polarity
    localparam int          F_DIV_LSB    = 0;
    localparam int          F_EDGE_LSB   = 4;
    localparam logic [7:0]  PS_RST       = 8'h00;
    localparam logic [15:0] MATCH_RST    = 16'h0000;

    // interrupt status layout, three bits per channel
    localparam int          IRQ_PER_CH   = 3;
    localparam int          IRQ_W        = 6;
    localparam int          I_MATCH_A    = 0;
    localparam int          I_MATCH_B    = 1;
    localparam int          I_WRAP       = 2;

    typedef enum logic [1:0] {
        RUN_STOP  = 2'b00,
        RUN_FREE  = 2'b01,
        RUN_EDGE  = 2'b10,
        RUN_MATCH = 2'b11
    } tmc_run_e;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_NONE = 2'b10,
        EDGE_BOTH = 2'b11
    } tmc_edge_e;

    function automatic logic [31:0] ch_addr(input int c,
                                            input logic [31:0] ofs);
        logic [31:0] base;
        base = CH_STRIDE * 32'(c);
        return base + ofs;
    endfunction : ch_addr
endpackage : tmc_pkg

/* File: rtl/tmc_edge_det.sv */
// valid edge detector for the external trigger input
`timescale 1ns/1ns
module tmc_edge_det (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       pin,
    input  wire logic [1:0] pol,
    output logic            hit
);
    logic prevQ;
    logic prevD;

    always_comb begin
        prevD = pin;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            prevQ <= 1'b0;
        end else begin
            prevQ <= prevD;
        end
    end

    // polarity comes from the prescale setting only
    always_comb begin
        unique case (tmc_pkg::tmc_edge_e'(pol))
            tmc_pkg::EDGE_FALL: hit = prevQ & ~pin;
            tmc_pkg::EDGE_RISE: hit = ~prevQ & pin;
            tmc_pkg::EDGE_NONE: hit = 1'b0;
            tmc_pkg::EDGE_BOTH: hit = prevQ ^ pin;
        endcase
    end
endmodule : tmc_edge_det

/* File: rtl/tmc_count_div.sv */
// count clock enable divider, held at zero while stopped
`timescale 1ns/1ns
module tmc_count_div (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       run,
    input  wire logic [1:0] sel,
    output logic            tick
);
    logic [2:0] cntQ;
    logic [2:0] cntD;
    logic [2:0] mask;

    always_comb begin
        mask = 3'((4'h1 << sel) - 4'h1);
        // zero phase while stopped gives a tick on the first run cycle
        tick = run & ((cntQ & mask) == 3'h0);
        cntD = run ? 3'(cntQ + 3'h1) : 3'h0;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cntQ <= 3'h0;
        end else begin
            cntQ <= cntD;
        end
    end
endmodule : tmc_count_div

/* File: rtl/tmc_timer_mode_control.sv */
// two channel 16-bit timer mode control with apb register access
// Overview of operation
// - reset clears mode control register to zero
// - byte and single bit accesses supported
// - counting starts when run field nonzero
// - run field zero stops, gates, clears counter
// - modes: free, edge restart, match restart
// - output toggles on matches, optionally edges
// - counter wrap sets overflow flag
// - flag cleared by writing zero or stopping
// - writing one sets the overflow flag unless run field zero
// - edge polarity from prescale setting
// - counter increments on each count tick
// - compare match raises its interrupt request
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module tmc_timer_mode_control (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [31:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  edgeInA,
    output logic      [1:0]  toggleOut,
    output logic      [1:0]  matchAIrq,
    output logic      [1:0]  matchBIrq,
    output logic             irq
);
    localparam int NCH = tmc_pkg::NCH;

    logic [1:0]  runModeQ   [NCH];
    logic [1:0]  runModeD   [NCH];
    logic        tselQ      [NCH];
    logic        tselD      [NCH];
    logic        wrapFlagQ  [NCH];
    logic        wrapFlagD  [NCH];
    logic [15:0] matchRegAQ [NCH];
    logic [15:0] matchRegAD [NCH];
    logic [15:0] matchRegBQ [NCH];
    logic [15:0] matchRegBD [NCH];
    logic [7:0]  prescaleQ  [NCH];
    logic [7:0]  prescaleD  [NCH];
    logic [15:0] cntQ       [NCH];
    logic [15:0] cntD       [NCH];
    logic [1:0]  toggleQ;
    logic [1:0]  toggleD;
    logic [1:0]  irqAQ;
    logic [1:0]  irqAD;
    logic [1:0]  irqBQ;
    logic [1:0]  irqBD;
    logic [tmc_pkg::IRQ_W-1:0] statQ;
    logic [tmc_pkg::IRQ_W-1:0] statD;
    logic [tmc_pkg::IRQ_W-1:0] maskQ;
    logic [tmc_pkg::IRQ_W-1:0] maskD;
    logic [31:0] rdataQ;
    logic [31:0] rdataD;

    logic [NCH-1:0] run;
    logic [NCH-1:0] tick;
    logic [NCH-1:0] edgeHit;
    logic [NCH-1:0] matchA;
    logic [NCH-1:0] matchB;
    logic [NCH-1:0] wrap;
    logic [NCH-1:0] restart;
    logic           wrAcc;
    logic           setup;
    logic           mapped;
    logic [7:0]     modeByte  [NCH];

    function automatic logic [7:0] mode_byte(input logic [1:0] rm,
                                             input logic ts,
                                             input logic wf);
        logic [7:0] b;
        b = 8'h00;
        b[tmc_pkg::F_RUN_HI:tmc_pkg::F_RUN_LO] = rm;
        b[tmc_pkg::F_TSEL] = ts;
        b[tmc_pkg::F_WRAP] = wf;
        return b;
    endfunction : mode_byte

    function automatic logic [31:0] mode_addr(input int c);
        return (c == 0) ? tmc_pkg::ADDR_MODE0 : tmc_pkg::ADDR_MODE1;
    endfunction : mode_addr

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            tmc_count_div u_div (
                .sys_clk (sys_clk),
                .nrst    (nrst),
                .run     (run[g]),
                .sel     (prescaleQ[g][tmc_pkg::F_DIV_LSB +: 2]),
                .tick    (tick[g])
            );
            tmc_edge_det u_edge (
                .sys_clk (sys_clk),
                .nrst    (nrst),
                .pin     (edgeInA[g]),
                .pol     (prescaleQ[g][tmc_pkg::F_EDGE_LSB +: 2]),
                .hit     (edgeHit[g])
            );
        end
    endgenerate

    // counting events
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            modeByte[c] = mode_byte(runModeQ[c], tselQ[c], wrapFlagQ[c]);
            run[c]     = runModeQ[c] != tmc_pkg::RUN_STOP;
            matchA[c]  = run[c] & tick[c] & (cntQ[c] == matchRegAQ[c]);
            matchB[c]  = run[c] & tick[c] & (cntQ[c] == matchRegBQ[c]);
            wrap[c]    = run[c] & tick[c] & (cntQ[c] == tmc_pkg::MAX_COUNT);
            restart[c] = 1'b0;
            unique case (tmc_pkg::tmc_run_e'(runModeQ[c]))
                tmc_pkg::RUN_STOP:  restart[c] = 1'b0;
                tmc_pkg::RUN_FREE:  restart[c] = 1'b0;
                tmc_pkg::RUN_EDGE:  restart[c] = edgeHit[c];
                tmc_pkg::RUN_MATCH: restart[c] = matchA[c];
            endcase
            if (!run[c]) begin
                cntD[c] = 16'h0000;
            end else if (restart[c]) begin
                cntD[c] = 16'h0000;
            end else if (tick[c]) begin
                cntD[c] = 16'(cntQ[c] + 16'h0001);
            end else begin
                cntD[c] = cntQ[c];
            end
            // edge toggling only while running, stopped pin is quiet
            toggleD[c] = toggleQ[c] ^ (matchA[c] | matchB[c] |
                         (tselQ[c] & edgeHit[c] & run[c]));
            irqAD[c] = matchA[c];
            irqBD[c] = matchB[c];
        end
    end

    // apb: read data latched in setup, zero wait access phase
    always_comb begin
        setup  = psel & ~penable;
        wrAcc  = psel & penable & pwrite;
        mapped = (paddr == tmc_pkg::ADDR_IRQ_ST) |
                 (paddr == tmc_pkg::ADDR_IRQ_MSK);
        rdataD = rdataQ;
        for (int c = 0; c < NCH; c++) begin
            mapped = mapped | (paddr == mode_addr(c)) |
                (paddr == tmc_pkg::ch_addr(c, tmc_pkg::OFS_MATCH_A)) |
                (paddr == tmc_pkg::ch_addr(c, tmc_pkg::OFS_MATCH_B)) |
                (paddr == tmc_pkg::ch_addr(c, tmc_pkg::OFS_PRESCALE)) |
                (paddr == tmc_pkg::ch_addr(c, tmc_pkg::OFS_COUNT)) |
                (paddr == tmc_pkg::ch_addr(c, tmc_pkg::OFS_BITOP));
        end
        if (setup) begin
            rdataD = 32'h0000_0000;
            for (int c = 0; c < NCH; c++) begin
                if (paddr == mode_addr(c)) begin
                    rdataD = {24'h000000, modeByte[c]};
                end
                if (paddr == tmc_pkg::ch_addr(c, tmc_pkg::OFS_MATCH_A)) begin
                    rdataD = {16'h0000, matchRegAQ[c]};
                end
                if (paddr == tmc_pkg::ch_addr(c, tmc_pkg::OFS_MATCH_B)) begin
                    rdataD = {16'h0000, matchRegBQ[c]};
                end
                if (paddr == tmc_pkg::ch_addr(c, tmc_pkg::OFS_PRESCALE)) begin
                    rdataD = {24'h000000, prescaleQ[c]};
                end
                if (paddr == tmc_pkg::ch_addr(c, tmc_pkg::OFS_COUNT)) begin
                    rdataD = {16'h0000, cntQ[c]};
                end
            end
            if (paddr == tmc_pkg::ADDR_IRQ_ST) begin
                rdataD = {26'h0000000, statQ};
            end
            if (paddr == tmc_pkg::ADDR_IRQ_MSK) begin
                rdataD = {26'h0000000, maskQ};
            end
        end
        prdata  = rdataQ;
        pready  = 1'b1;
        pslverr = psel & penable & ~mapped;
    end

    // register writes
    always_comb begin
        logic [7:0] nb;
        logic [2:0] bi;
        nb    = 8'h00;
        bi    = 3'h0;
        maskD = maskQ;
        statD = statQ;
        if (wrAcc && pstrb[0] && paddr == tmc_pkg::ADDR_IRQ_MSK) begin
            maskD = pwdata[tmc_pkg::IRQ_W-1:0];
        end
        if (wrAcc && pstrb[0] && paddr == tmc_pkg::ADDR_IRQ_ST) begin
            statD = statQ & ~pwdata[tmc_pkg::IRQ_W-1:0];
        end
        for (int c = 0; c < NCH; c++) begin
            runModeD[c]   = runModeQ[c];
            tselD[c]      = tselQ[c];
            wrapFlagD[c]  = wrapFlagQ[c];
            matchRegAD[c] = matchRegAQ[c];
            matchRegBD[c] = matchRegBQ[c];
            prescaleD[c]  = prescaleQ[c];
            nb = modeByte[c];
            // whole byte write, or single bit write through the bit port
            if (wrAcc && pstrb[0] && paddr == mode_addr(c)) begin
                nb = pwdata[7:0];
            end
            bi = pwdata[2:0];
            if (wrAcc && pstrb[0] && bi <= tmc_pkg::BIT_IDX_MAX &&
                paddr == tmc_pkg::ch_addr(c, tmc_pkg::OFS_BITOP)) begin
                nb[bi] = pwdata[tmc_pkg::F_BITVAL];
            end
            runModeD[c] = nb[tmc_pkg::F_RUN_HI:tmc_pkg::F_RUN_LO];
            tselD[c]    = nb[tmc_pkg::F_TSEL];
            // write 1 sets, write 0 or a stop clears, hardware set wins
            wrapFlagD[c] = (nb[tmc_pkg::F_WRAP] &
                (runModeD[c] != tmc_pkg::RUN_STOP)) | wrap[c];
            if (wrAcc && (pstrb[1:0] == 2'b11) &&
                paddr == tmc_pkg::ch_addr(c, tmc_pkg::OFS_MATCH_A)) begin
                matchRegAD[c] = pwdata[15:0];
            end
            if (wrAcc && (pstrb[1:0] == 2'b11) &&
                paddr == tmc_pkg::ch_addr(c, tmc_pkg::OFS_MATCH_B)) begin
                matchRegBD[c] = pwdata[15:0];
            end
            if (wrAcc && pstrb[0] &&
                paddr == tmc_pkg::ch_addr(c, tmc_pkg::OFS_PRESCALE)) begin
                prescaleD[c] = pwdata[7:0];
            end
            statD[c*tmc_pkg::IRQ_PER_CH + tmc_pkg::I_MATCH_A] =
                statD[c*tmc_pkg::IRQ_PER_CH + tmc_pkg::I_MATCH_A] | matchA[c];
            statD[c*tmc_pkg::IRQ_PER_CH + tmc_pkg::I_MATCH_B] =
                statD[c*tmc_pkg::IRQ_PER_CH + tmc_pkg::I_MATCH_B] | matchB[c];
            statD[c*tmc_pkg::IRQ_PER_CH + tmc_pkg::I_WRAP] =
                statD[c*tmc_pkg::IRQ_PER_CH + tmc_pkg::I_WRAP] | wrap[c];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int c = 0; c < NCH; c++) begin
                runModeQ[c]   <= tmc_pkg::RUN_STOP;
                tselQ[c]      <= tmc_pkg::MODE_RST[tmc_pkg::F_TSEL];
                wrapFlagQ[c]  <= tmc_pkg::MODE_RST[tmc_pkg::F_WRAP];
                matchRegAQ[c] <= tmc_pkg::MATCH_RST;
                matchRegBQ[c] <= tmc_pkg::MATCH_RST;
                prescaleQ[c]  <= tmc_pkg::PS_RST;
                cntQ[c]       <= 16'h0000;
            end
            toggleQ <= 2'b00;
            irqAQ   <= 2'b00;
            irqBQ   <= 2'b00;
            statQ   <= '0;
            maskQ   <= '0;
            rdataQ  <= 32'h0000_0000;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                runModeQ[c]   <= runModeD[c];
                tselQ[c]      <= tselD[c];
                wrapFlagQ[c]  <= wrapFlagD[c];
                matchRegAQ[c] <= matchRegAD[c];
                matchRegBQ[c] <= matchRegBD[c];
                prescaleQ[c]  <= prescaleD[c];
                cntQ[c]       <= cntD[c];
            end
            toggleQ <= toggleD;
            irqAQ   <= irqAD;
            irqBQ   <= irqBD;
            statQ   <= statD;
            maskQ   <= maskD;
            rdataQ  <= rdataD;
        end
    end

    always_comb begin
        toggleOut = toggleQ;
        matchAIrq = irqAQ;
        matchBIrq = irqBQ;
        irq       = |(statQ & maskQ);
    end

    // checks on channel 0
    property p_reset_zero;
        @(posedge sys_clk) !nrst |=> modeByte[0] == tmc_pkg::MODE_RST;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("mode register not zero after reset");

    property p_byte_write;
        @(posedge sys_clk) disable iff (!nrst)
        wrAcc && pstrb[0] && paddr == tmc_pkg::ADDR_MODE0
        |=> runModeQ[0] == $past(pwdata[3:2]) && tselQ[0] == $past(pwdata[1]);
    endproperty
    a_byte_write: assert property (p_byte_write)
        else $error("byte write to mode register lost");

    property p_run_start;
        @(posedge sys_clk) disable iff (!nrst)
        $rose(runModeQ[0] == tmc_pkg::RUN_FREE) ##0 cntQ[0] == 16'h0000
        |=> cntQ[0] == 16'h0001;
    endproperty
    a_run_start: assert property (p_run_start)
        else $error("counter did not start with run field");

    property p_stop_clear;
        @(posedge sys_clk) disable iff (!nrst)
        !run[0] |=> cntQ[0] == 16'h0000;
    endproperty
    a_stop_clear: assert property (p_stop_clear)
        else $error("counter not held clear while stopped");

    property p_edge_restart;
        @(posedge sys_clk) disable iff (!nrst)
        runModeQ[0] == tmc_pkg::RUN_EDGE && edgeHit[0] |=> cntQ[0] == 16'h0;
    endproperty
    a_edge_restart: assert property (p_edge_restart)
        else $error("edge did not restart counter");

    property p_toggle;
        @(posedge sys_clk) disable iff (!nrst)
        (matchA[0] | matchB[0]) && !(tselQ[0] && edgeHit[0])
        |=> toggleOut[0] != $past(toggleOut[0]);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("output did not invert on match");

    property p_wrap_set;
        @(posedge sys_clk) disable iff (!nrst)
        run[0] && tick[0] && cntQ[0] == tmc_pkg::MAX_COUNT
        |=> wrapFlagQ[0] && cntQ[0] == 16'h0000;
    endproperty
    a_wrap_set: assert property (p_wrap_set)
        else $error("wrap did not set overflow flag");

    property p_stop_flag;
        @(posedge sys_clk) disable iff (!nrst)
        wrAcc && pstrb[0] && paddr == tmc_pkg::ADDR_MODE0 &&
        pwdata[3:2] == 2'b00 |=> !wrapFlagQ[0] ##1 !wrapFlagQ[0];
    endproperty
    a_stop_flag: assert property (p_stop_flag)
        else $error("stop did not clear overflow flag");

    property p_sw_set;
        @(posedge sys_clk) disable iff (!nrst)
        wrAcc && pstrb[0] && paddr == tmc_pkg::ADDR_MODE0 &&
        pwdata[0] && pwdata[3:2] != 2'b00 |=> wrapFlagQ[0];
    endproperty
    a_sw_set: assert property (p_sw_set)
        else $error("software write did not set flag");

    property p_match_irq;
        @(posedge sys_clk) disable iff (!nrst)
        matchA[0] |=> matchAIrq[0] ##1 statQ[tmc_pkg::I_MATCH_A];
    endproperty
    a_match_irq: assert property (p_match_irq)
        else $error("match did not raise request");
endmodule : tmc_timer_mode_control

/* File: sim/tmc_pin_model.sv */
// far side pins: external trigger driver and timer output watcher
`timescale 1ns/1ns
module tmc_pin_model (
    input  wire logic       sys_clk,
    input  wire logic [1:0] toggleOut,
    output logic      [1:0] edgeInA
);
    int         flips [2];
    logic [1:0] lastOut;

    initial begin
        edgeInA = 2'h0;
        lastOut = 2'h0;
        flips   = '{0, 0};
    end

    // trigger and output kept on separate pins
    always @(posedge sys_clk) begin
        for (int c = 0; c < 2; c++) begin
            if (toggleOut[c] !== lastOut[c]) flips[c]++;
        end
        lastOut <= toggleOut;
    end

    // pin is a held level, changed just after an edge
    task automatic setPin(input int c, input logic v);
        @(posedge sys_clk);
        edgeInA[c] <= v;
    endtask : setPin
endmodule : tmc_pin_model

/* File: sim/timer_mode_control_bench.sv */
// self-checking bench for the timer mode control block
`timescale 1ns/1ns
module timer_mode_control_bench;
    logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0] paddr, pwdata, prdata, rd, c0;
    logic [3:0]  pstrb;
    logic [1:0]  edgeInA, toggleOut, matchAIrq, matchBIrq;
    logic        er;
    int          n_fail, cmp_count, f0, t;

    tmc_timer_mode_control i_dut (.sys_clk(sys_clk), .nrst(nrst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .edgeInA(edgeInA), .toggleOut(toggleOut),
        .matchAIrq(matchAIrq), .matchBIrq(matchBIrq), .irq(irq));
    tmc_pin_model i_pins (.sys_clk(sys_clk), .toggleOut(toggleOut),
        .edgeInA(edgeInA));

    always #2 sys_clk = ~sys_clk;

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a stuck transfer
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // bounded wait for a channel 0 match pulse, b picks a or b
    task automatic waitIrq(input logic b, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((b ? matchBIrq[0] : matchAIrq[0]) !== 1'b1 && n < 100);
        if (n >= 100) begin
            n_fail++;
            conclude();
        end
    endtask : waitIrq

    task automatic tResetMap();
        apb(0, tmc_pkg::ADDR_MODE0, 0);
        chk("mode0", 32'h0, rd);
        apb(0, tmc_pkg::ADDR_MODE1, 0);
        chk("mode1", 32'h0, rd);
        apb(1, tmc_pkg::ADDR_MODE1, 32'h0000_00f0);
        apb(0, tmc_pkg::ADDR_MODE1, 0);
        chk("hi0", 32'h0, rd);
        apb(0, 32'h0000_0080, 0);
        chk("err", 32'h1, {31'h0, er});
        chk("unmap", 32'h0, rd);
    endtask : tResetMap

    task automatic tFreeWrap();
        apb(1, tmc_pkg::OFS_BITOP, 32'h0000_000a);
        apb(0, tmc_pkg::ADDR_MODE0, 0);
        chk("run", 32'h4, rd);
        apb(0, tmc_pkg::OFS_COUNT, 0);
        c0 = rd;
        apb(0, tmc_pkg::OFS_COUNT, 0);
        chk("step", c0 + 3, rd);
        repeat (65536) @(posedge sys_clk);
        apb(0, tmc_pkg::ADDR_MODE0, 0);
        chk("wrap", 32'h5, rd);
        apb(0, tmc_pkg::ADDR_IRQ_ST, 0);
        chk("wst", 32'h1, {31'h0, rd[2]});
        repeat (2) @(posedge sys_clk);
        chk("irqm", 32'h0, {31'h0, irq});
        apb(1, tmc_pkg::ADDR_IRQ_MSK, 32'h4);
        repeat (2) @(posedge sys_clk);
        chk("irq1", 32'h1, {31'h0, irq});
        apb(1, tmc_pkg::ADDR_IRQ_ST, 32'h4);
        repeat (2) @(posedge sys_clk);
        chk("irq0", 32'h0, {31'h0, irq});
        // flag clear only, run kept
        apb(1, tmc_pkg::ADDR_MODE0, 32'h4);
        apb(0, tmc_pkg::ADDR_MODE0, 0);
        chk("clr", 32'h4, rd);
        apb(1, tmc_pkg::ADDR_MODE0, 32'h0);
        apb(0, tmc_pkg::OFS_COUNT, 0);
        chk("stop", 32'h0, rd);
        // start and set the flag in one write, legal while stopped
        apb(1, tmc_pkg::ADDR_MODE0, 32'h5);
        apb(0, tmc_pkg::ADDR_MODE0, 0);
        chk("swset", 32'h5, rd);
        apb(1, tmc_pkg::ADDR_MODE0, 32'h0);
        apb(0, tmc_pkg::ADDR_MODE0, 0);
        chk("stopf", 32'h0, rd);
        // divide by four: ticks on run cycles 0, 4, 8 and 12
        apb(1, tmc_pkg::OFS_PRESCALE, 32'h2);
        apb(1, tmc_pkg::ADDR_MODE0, 32'h4);
        repeat (12) @(posedge sys_clk);
        apb(0, tmc_pkg::OFS_COUNT, 0);
        chk("div4", 32'h4, rd);
        apb(1, tmc_pkg::ADDR_MODE0, 32'h0);
        apb(1, tmc_pkg::OFS_PRESCALE, 32'h0);
    endtask : tFreeWrap

    task automatic tMatch();
        apb(1, tmc_pkg::OFS_MATCH_A, 32'h5);
        apb(1, tmc_pkg::OFS_MATCH_B, 32'h3);
        apb(1, tmc_pkg::ADDR_MODE0, 32'hc);
        waitIrq(1'b0, t);
        #1 f0 = i_pins.flips[0];
        waitIrq(1'b1, t);
        chk("bgap", 32'd4, 32'(t));
        waitIrq(1'b0, t);
        chk("rest", 32'd2, 32'(t));
        #1 chk("tgl", 32'd2, 32'(i_pins.flips[0] - f0));
        waitIrq(1'b0, t);
        chk("period", 32'd6, 32'(t));
        apb(1, tmc_pkg::ADDR_MODE0, 32'h0);
    endtask : tMatch

    task automatic tEdge();
        apb(1, tmc_pkg::OFS_MATCH_A, 32'hff00);
        apb(1, tmc_pkg::OFS_MATCH_B, 32'hff01);
        apb(1, tmc_pkg::OFS_PRESCALE, 32'h10);
        apb(1, tmc_pkg::ADDR_MODE0, 32'ha);
        repeat (20) @(posedge sys_clk);
        f0 = i_pins.flips[0];
        i_pins.setPin(0, 1'b1);
        apb(0, tmc_pkg::OFS_COUNT, 0);
        chk("rst", 32'h1, {31'h0, rd < 8});
        repeat (10) @(posedge sys_clk);
        i_pins.setPin(0, 1'b0);
        apb(0, tmc_pkg::OFS_COUNT, 0);
        chk("fall", 32'h1, {31'h0, rd > 9});
        #1 chk("etgl", 32'd1, 32'(i_pins.flips[0] - f0));
        apb(1, tmc_pkg::ADDR_MODE0, 32'h0);
    endtask : tEdge

    initial begin
        repeat (100000) @(posedge sys_clk);
        n_fail++;
        conclude();
    end

    initial begin
        sys_clk = 1'b0;
        nrst    = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 32'h0;
        pwdata  = 32'h0;
        pstrb   = 4'hf;
        // register access only with the system clock running
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        tResetMap();
        tFreeWrap();
        tMatch();
        tEdge();
        conclude();
    end
endmodule : timer_mode_control_bench
